// [dash_pkg.sv]
// Shared constants, types and register map for the dashboard indicator logic
// *************************************************************************
// *************************************************************************
package dash_pkg;
  // Register byte offsets
  localparam logic [11:0] OFF_CTRL = 12'h000; // Unit, hour select, blink period
  localparam logic [11:0] OFF_STATE = 12'h004; // Lamps, level, icons (read only)
  localparam logic [11:0] OFF_HOURS = 12'h008; // Shown hour counter (read only)
  localparam logic [11:0] OFF_SEGS = 12'h00c; // Segment images (read only)
  // Control field positions
  localparam int CTRL_MPH_BIT = 0;
  localparam int CTRL_SEL_LSB = 1;
  localparam int CTRL_BLINK_LSB = 8;
  // Reset values
  localparam logic [1:0] SEL_RESET = 2'h0;
  localparam logic [15:0] BLINK_RESET = 16'h0032; // Half periods in ms ticks
  localparam logic [2:0] LEVEL_TOP = 3'h4;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_MHZ * TICK_US;
  localparam int TEST_STEP_MS = 200;
  localparam int HOUR_TICKS = 3600000;
  // Charge thresholds in percent
  localparam logic [6:0] LOW_PCT = 7'h28;
  // Hour selector letters
  typedef enum logic [1:0] {SEL_KEY, SEL_SEAT, SEL_MACHINE} hour_sel_t;
  // Truck state received from the CAN front end
  typedef struct packed {
    logic [6:0] charge_pct; // Residual charge 0..100
    logic any_alarm;
    logic heatsink_alarm; // power_stage_heatsink overtemperature
    logic low_charge_alarm;
    logic seat;
    logic handbrake;
    logic key;
    logic soft_mode;
    logic fwd;
    logic rev;
    logic running;
    logic traction_work;
    logic pump_work;
    logic [7:0] accel; // 0 minimum, 255 maximum
    logic [7:0] steer; // 0 full left, 255 full right
    logic [11:0] speed_kmh10; // Tenths of km/h
  } truck_t;
  // Display image
  typedef struct packed {
    logic [4:0] lamps; // Charge, fault, temp, seat, brake
    logic [9:0] charge_seg;
    logic batt_icon;
    logic [2:0] level;
    logic turtle;
    logic [7:0] letter; // ASCII K/S/M
    logic [7:0] accel_seg;
    logic [11:0] speed;
    logic [8:0] steer_seg;
    logic arrow_up;
    logic arrow_dn;
    logic dot;
  } disp_t;
endpackage

// [dash_ind.sv]
// Dashboard lamp and segment driver with APB register access
module dash_ind #(
  parameter int TICK_DIV = dash_pkg::TICK_CYC,
  parameter int HOUR_DIV = dash_pkg::HOUR_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire dash_pkg::truck_t truck,
  input wire logic button_pin,
  output dash_pkg::disp_t disp,
  output logic [2:0] level_tx,
  output logic level_tx_stb
);
  import dash_pkg::*;

  // Dividers below two would hold the enables high on every cycle
  if (TICK_DIV < 2 || HOUR_DIV < 2) begin : g_bad_div
    $error("dash_ind: dividers too small");
  end

  // *********************************************************************
  // Timebase
  // *********************************************************************
  logic [31:0] tick_cnt_q; // Millisecond divider
  logic tick; // One-cycle ms enable
  assign tick = (tick_cnt_q == 32'(TICK_DIV - 1));

  // Millisecond enable divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_q <= 32'h0;
    end else if (tick) begin
      tick_cnt_q <= 32'h0;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
    end
  end

  // *********************************************************************
  // Registers
  // *********************************************************************
  logic mph_q; // Speed unit select
  hour_sel_t sel_q; // Hour counter shown
  logic [15:0] blink_half_q; // Blink half period, ms
  logic wr_en;
  assign wr_en = psel && penable && pwrite;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = 1'b0;

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mph_q <= 1'b0;
      sel_q <= hour_sel_t'(SEL_RESET);
      blink_half_q <= BLINK_RESET;
    end else if (wr_en && paddr == OFF_CTRL) begin
      mph_q <= pwdata[CTRL_MPH_BIT];
      // Code 3 is unused; fall back to key hours
      if (pwdata[CTRL_SEL_LSB +: 2] == 2'h3) begin
        sel_q <= SEL_KEY;
      end else begin
        sel_q <= hour_sel_t'(pwdata[CTRL_SEL_LSB +: 2]);
      end
      // Zero would freeze blinking; clamp to one
      blink_half_q <= (pwdata[CTRL_BLINK_LSB +: 16] == 16'h0) ? 16'h1
                      : pwdata[CTRL_BLINK_LSB +: 16];
    end
  end

  // *********************************************************************
  // Blink timebase
  // *********************************************************************
  logic [15:0] blink_cnt_q;
  logic blink_q; // Shared phase, high = on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_q <= 16'h0;
      blink_q <= 1'b0;
    end else if (tick) begin
      if (blink_cnt_q >= blink_half_q - 16'h1) begin
        blink_cnt_q <= 16'h0;
        blink_q <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 16'h1;
      end
    end
  end

  // *********************************************************************
  // Pin synchroniser and button edge
  // *********************************************************************
  logic btn_s1_q;
  logic btn_s2_q;
  logic btn_s3_q; // Previous synced level for edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_s3_q <= 1'b0;
    end else begin
      btn_s1_q <= button_pin;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
    end
  end
  logic press;
  assign press = btn_s2_q && !btn_s3_q;

  // *********************************************************************
  // Performance level
  // *********************************************************************
  logic [2:0] level_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_q <= LEVEL_TOP;
    end else if (press) begin
      level_q <= (level_q == 3'h1) ? LEVEL_TOP : level_q - 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_tx_stb <= 1'b0;
      level_tx <= LEVEL_TOP;
    end else begin
      level_tx_stb <= press;
      if (press) begin
        level_tx <= (level_q == 3'h1) ? LEVEL_TOP : level_q - 3'h1;
      end
    end
  end

  // *********************************************************************
  // Lamp self-test on key closing
  // *********************************************************************
  typedef enum logic [1:0] {T_IDLE, T_ON, T_OFF} test_st_t;
  test_st_t test_q;
  logic [2:0] test_idx_q; // Lamp under test
  logic [15:0] test_ms_q;
  logic key_d_q; // Previous key level
  // one lamp on then off in turn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_q <= T_IDLE;
      test_idx_q <= 3'h0;
      test_ms_q <= 16'h0;
      key_d_q <= 1'b0;
    end else begin
      key_d_q <= truck.key;
      case (test_q)
        T_IDLE: begin
          if (truck.key && !key_d_q) begin
            test_q <= T_ON;
            test_idx_q <= 3'h0;
            test_ms_q <= 16'h0;
          end
        end
        T_ON, T_OFF: begin
          if (tick) begin
            if (test_ms_q == 16'(TEST_STEP_MS - 1)) begin
              test_ms_q <= 16'h0;
              if (test_q == T_ON) begin
                test_q <= T_OFF;
              end else if (test_idx_q == 3'h4) begin
                test_q <= T_IDLE;
              end else begin
                test_q <= T_ON;
                test_idx_q <= test_idx_q + 3'h1;
              end
            end else begin
              test_ms_q <= test_ms_q + 16'h1;
            end
          end
        end
        default: test_q <= T_IDLE;
      endcase
    end
  end

  // *********************************************************************
  // Hour counters
  // *********************************************************************
  logic [31:0] ms_acc_q [3]; // Millisecond accumulators per counter
  logic [19:0] hours_q [3];
  logic [2:0] count_en;
  assign count_en = {truck.traction_work || truck.pump_work, truck.seat, truck.key};
  // One counter per hour source
  for (genvar g = 0; g < 3; g++) begin : g_hours
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ms_acc_q[g] <= 32'h0;
        hours_q[g] <= 20'h0;
      end else if (tick && count_en[g]) begin
        if (ms_acc_q[g] == 32'(HOUR_DIV - 1)) begin
          ms_acc_q[g] <= 32'h0;
          hours_q[g] <= hours_q[g] + 20'h1;
        end else begin
          ms_acc_q[g] <= ms_acc_q[g] + 32'h1;
        end
      end
    end
  end

  // *********************************************************************
  // Display image
  // *********************************************************************
  disp_t img;
  logic low_chg;
  logic [3:0] steer_pos;
  logic [10:0] accel_n; // Segments lit, 1..8
  logic [19:0] speed_full; // Converted speed
  assign low_chg = truck.charge_pct <= LOW_PCT;
  assign steer_pos = 4'((12'(truck.steer) * 12'd9) >> 8);
  assign accel_n = 11'((11'(truck.accel) * 11'd7 + 11'd127) / 11'd255) + 11'd1;
  // mph = km/h * 159 / 256 approximately (ratio 0.621)
  assign speed_full = mph_q ? ((20'(truck.speed_kmh10) * 20'd159) >> 8)
                            : 20'(truck.speed_kmh10);

  // Combinational segment image
  always_comb begin
    img = '0;
    img.lamps[4] = low_chg;
    img.lamps[3] = truck.any_alarm && blink_q;
    img.lamps[2] = truck.heatsink_alarm && blink_q;
    img.lamps[1] = truck.seat;
    img.lamps[0] = truck.handbrake;
    if (test_q != T_IDLE) begin
      img.lamps = '0;
      img.lamps[3'h4 - test_idx_q] = (test_q == T_ON);
    end
    // one segment per ten percent, blinking when low
    for (int i = 0; i < 10; i++) begin
      img.charge_seg[i] = (truck.charge_pct > 7'(i * 10)) && (!low_chg || blink_q);
    end
    img.batt_icon = !truck.low_charge_alarm || blink_q;
    img.level = level_q;
    img.turtle = truck.soft_mode;
    case (sel_q)
      SEL_SEAT: img.letter = 8'h53;
      SEL_MACHINE: img.letter = 8'h4d;
      default: img.letter = 8'h4b;
    endcase
    for (int i = 0; i < 8; i++) begin
      img.accel_seg[i] = accel_n > 11'(i);
    end
    img.speed = speed_full[11:0];
    img.steer_seg[steer_pos] = 1'b1;
    img.arrow_up = truck.running && truck.fwd;
    img.arrow_dn = truck.running && truck.rev && !truck.fwd;
    img.dot = !img.arrow_up && !img.arrow_dn;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp <= '0;
      disp.level <= LEVEL_TOP;
    end else begin
      disp <= img;
    end
  end

  // *********************************************************************
  // Read data
  // *********************************************************************
  logic [31:0] rd_d;
  always_comb begin
    if (paddr == OFF_CTRL) begin
      rd_d = {8'h0, blink_half_q, 5'h0, 2'(sel_q), mph_q};
    end else if (paddr == OFF_STATE) begin
      rd_d = {20'h0, 2'(test_q), disp.turtle, disp.level, disp.batt_icon, disp.lamps};
    end else if (paddr == OFF_HOURS) begin
      rd_d = {12'h0, hours_q[sel_q]};
    end else if (paddr == OFF_SEGS) begin
      rd_d = {5'h0, disp.steer_seg, disp.accel_seg, disp.charge_seg};
    end else begin
      rd_d = 32'h0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_d;
    end
  end

  // *********************************************************************
  // Checks
  // *********************************************************************
  chk_charge_lamp: assert property (@(posedge pclk) disable iff (!presetn)
    (test_q == T_IDLE) ##1 (test_q == T_IDLE) |-> disp.lamps[4] == $past(low_chg))
    else $error("charge lamp wrong");
  chk_fault_dark: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!truck.any_alarm && test_q == T_IDLE) && test_q == T_IDLE |-> !disp.lamps[3])
    else $error("fault lamp lit without alarm");
  chk_seat_lamp: assert property (@(posedge pclk) disable iff (!presetn)
    $past(test_q == T_IDLE) && test_q == T_IDLE |-> disp.lamps[1] == $past(truck.seat))
    else $error("seat lamp wrong");
  chk_level_step: assert property (@(posedge pclk) disable iff (!presetn)
    press && level_q == 3'h3 |=> level_q == 3'h2)
    else $error("level not stepped");
  chk_level_send: assert property (@(posedge pclk) disable iff (!presetn)
    press |=> level_tx_stb && level_tx == level_q)
    else $error("level not sent");
  chk_steer_onehot: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> $onehot(disp.steer_seg))
    else $error("steering not one-hot");
  chk_accel_min: assert property (@(posedge pclk) disable iff (!presetn)
    $past(truck.accel) == 8'h0 && $past(presetn) |-> disp.accel_seg == 8'h01)
    else $error("accel minimum wrong");
  chk_arrow_dot: assert property (@(posedge pclk) disable iff (!presetn)
    $past(!truck.running) && $past(presetn) |-> disp.dot && !disp.arrow_up)
    else $error("dot missing when stopped");
  chk_test_start: assert property (@(posedge pclk) disable iff (!presetn)
    test_q == T_IDLE && truck.key && !key_d_q |=> test_q == T_ON ##1 disp.lamps == 5'h10)
    else $error("self-test did not start");
endmodule

// [can_peer.sv]
// Far-side controllers model: receives the selected performance level
module can_peer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] level_tx,
  input wire logic level_tx_stb,
  output logic [2:0] rx_level,
  output logic [7:0] rx_count,
  output logic [1:0] perf_rank
);
  timeunit 1ns;
  timeprecision 1ns;
  // *****************************
  // Level reception
  // *****************************
  // latch level on each strobe
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_level <= 3'h4;
      rx_count <= 8'h00;
    end else if (level_tx_stb) begin
      rx_level <= level_tx;
      rx_count <= rx_count + 8'h01;
    end
  end
  // four highest down to one minimum
  always_comb begin
    case (rx_level)
      3'h4: perf_rank = 2'h3;
      3'h3: perf_rank = 2'h2;
      3'h2: perf_rank = 2'h1;
      // Out-of-range levels treated as minimum, the safe side
      default: perf_rank = 2'h0;
    endcase
  end
endmodule

// [testbench.sv]
// Self-checking bench for the dashboard lamp and segment driver
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import dash_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, button_pin, pready, pslverr, stb;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, h1;
  logic [2:0] level_tx, rx_level;
  logic [7:0] rx_count;
  logic [1:0] perf_rank;
  truck_t tr;
  disp_t disp, e;
  int fails, num_checks, on, idx;
  dash_ind #(.TICK_DIV(4), .HOUR_DIV(5)) dash_ind_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .truck(tr),
    .button_pin(button_pin), .disp(disp), .level_tx(level_tx), .level_tx_stb(stb));
  can_peer can_peer_i (.pclk(pclk), .presetn(presetn), .level_tx(level_tx),
    .level_tx_stb(stb), .rx_level(rx_level), .rx_count(rx_count), .perf_rank(perf_rank));
  // *****************************
  // Helpers
  // *****************************
  // 10 ns clock
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task test_done;
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Step n edges; drivers always start right after an edge
  task go(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer, held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    go(1);
    penable <= 1'b1;
    n = 0;
    go(1);
    while (pready !== 1'b1 && n < 50) begin go(1); n++; end
    if (n == 50) begin fails++; test_done(); end
    rd = prdata;
    psel <= 1'b0; penable <= 1'b0;
    // Idle edge so a following setup never reassigns psel in this step
    go(1);
  endtask
  // Settle inputs, then look mid-cycle
  task look;
    go(3);
    @(negedge pclk);
  endtask
  // Button press; waits for the level strobe under a bound
  task press(input logic [2:0] lv);
    int n;
    button_pin <= 1'b1;
    n = 0;
    go(1);
    while (stb !== 1'b1 && n < 20) begin go(1); n++; end
    if (n == 20) begin fails++; test_done(); end
    chk(level_tx, lv);
    button_pin <= 1'b0;
    look();
    chk(disp.level, lv);
    chk(rx_level, lv);
    @(posedge pclk);
  endtask
  // *****************************
  // Main sequence
  // *****************************
  initial begin
    fails = 0; num_checks = 0;
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000;
    pwdata = 32'h0; button_pin = 1'b0; tr = '0; tr.charge_pct = 7'h64;
    go(5);
    @(negedge pclk);
    e = '0;
    e.level = LEVEL_TOP;
    chk(disp, e);
    chk(level_tx, 3'h4);
    @(posedge pclk);
    presetn <= 1'b1;
    go(1);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h00003200);
    apb(1'b1, OFF_STATE, 32'hffffffff);
    apb(1'b0, OFF_STATE, 32'h0);
    chk(rd[8:6], 3'h4);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(pslverr, 1'b0);
    // Steady lamps, charge threshold and boundary
    tr.seat <= 1'b1; tr.handbrake <= 1'b1; tr.charge_pct <= 7'h29; tr.soft_mode <= 1'b1;
    look();
    chk(disp.lamps, 5'h03);
    chk(disp.turtle, 1'b1);
    chk(disp.charge_seg, 10'h01f);
    @(posedge pclk);
    tr.seat <= 1'b0; tr.handbrake <= 1'b0; tr.charge_pct <= 7'h37; tr.soft_mode <= 1'b0;
    look();
    chk(disp.charge_seg, 10'h03f);
    chk(disp.lamps, 5'h00);
    chk(disp.turtle, 1'b0);
    @(posedge pclk);
    // Blinkers share one timebase; zero period clamps to one tick, 4 cycles
    apb(1'b1, OFF_CTRL, 32'h00000000);
    tr.charge_pct <= 7'h28; tr.any_alarm <= 1'b1;
    tr.heatsink_alarm <= 1'b1; tr.low_charge_alarm <= 1'b1;
    go(3);
    on = 0;
    repeat (24) begin
      @(negedge pclk);
      if (disp.charge_seg == 10'h00f) on++;
      chk(disp.charge_seg == 10'h000 || disp.charge_seg == 10'h00f, 1'b1);
      chk(disp.lamps[3], disp.charge_seg[0]);
      chk(disp.lamps[2], disp.charge_seg[0]);
      chk(disp.batt_icon, disp.charge_seg[0]);
      chk(disp.lamps[4], 1'b1);
    end
    chk(on > 6 && on < 18, 1'b1);
    @(posedge pclk);
    tr.any_alarm <= 1'b0; tr.heatsink_alarm <= 1'b0; tr.low_charge_alarm <= 1'b0;
    tr.charge_pct <= 7'h64;
    // Accelerator ends and middle, steering ends and middle
    tr.accel <= 8'h00; tr.steer <= 8'h00;
    look();
    chk(disp.accel_seg, 8'h01);
    chk(disp.steer_seg, 9'h001);
    chk(disp.lamps, 5'h00);
    chk(disp.batt_icon, 1'b1);
    @(posedge pclk);
    tr.accel <= 8'hff; tr.steer <= 8'hff;
    look();
    chk(disp.accel_seg, 8'hff);
    chk(disp.steer_seg, 9'h100);
    @(posedge pclk);
    tr.accel <= 8'h80; tr.steer <= 8'h80;
    look();
    chk(disp.accel_seg, 8'h1f);
    chk(disp.steer_seg, 9'h010);
    @(posedge pclk);
    // Speed units and direction
    tr.speed_kmh10 <= 12'h3e8; tr.running <= 1'b1; tr.fwd <= 1'b1;
    look();
    chk(disp.speed, 12'h3e8);
    chk({disp.arrow_up, disp.arrow_dn, disp.dot}, 3'h4);
    @(posedge pclk);
    apb(1'b1, OFF_CTRL, 32'h00000101);
    tr.fwd <= 1'b0; tr.rev <= 1'b1;
    look();
    chk(disp.speed, 12'h26d);
    chk({disp.arrow_up, disp.arrow_dn, disp.dot}, 3'h2);
    @(posedge pclk);
    tr.rev <= 1'b0; tr.running <= 1'b0;
    look();
    chk({disp.arrow_up, disp.arrow_dn, disp.dot}, 3'h1);
    @(posedge pclk);
    // Performance steps 4 to 1 and wraps
    press(3'h3);
    press(3'h2);
    press(3'h1);
    chk(perf_rank, 2'h0);
    press(3'h4);
    chk(perf_rank, 2'h3);
    chk(rx_count, 8'h04);
    // Hour selector letters and machine hours
    apb(1'b1, OFF_CTRL, 32'h00000100);
    look();
    chk(disp.letter, 8'h4b);
    @(posedge pclk);
    apb(1'b1, OFF_CTRL, 32'h00000102);
    look();
    chk(disp.letter, 8'h53);
    @(posedge pclk);
    // Unused selector code falls back to key hours
    apb(1'b1, OFF_CTRL, 32'h00000106);
    look();
    chk(disp.letter, 8'h4b);
    @(posedge pclk);
    apb(1'b1, OFF_CTRL, 32'h00000104);
    look();
    chk(disp.letter, 8'h4d);
    @(posedge pclk);
    apb(1'b0, OFF_HOURS, 32'h0);
    h1 = rd;
    go(100);
    apb(1'b0, OFF_HOURS, 32'h0);
    chk(rd, h1);
    tr.traction_work <= 1'b1;
    go(200);
    apb(1'b0, OFF_HOURS, 32'h0);
    chk(rd > h1, 1'b1);
    tr.traction_work <= 1'b0;
    // Lamp self-test on key closing, each lamp alone in turn
    tr.key <= 1'b1;
    idx = 0;
    e.lamps = 5'h00;
    repeat (9000) begin
      @(negedge pclk);
      if (disp.lamps != 5'h00 && disp.lamps !== e.lamps && idx < 5) begin
        chk(disp.lamps, 5'h10 >> idx);
        idx++;
      end
      e.lamps = disp.lamps;
    end
    chk(idx, 5);
    test_done();
  end
endmodule
